/* rtl/gpss_cmd_rom.sv */
// Command name table with registered read data
`timescale 1ns/1ps
module gpss_cmd_rom import gpss_pkg::*; (
	input wire logic ref_clk_in,
	gpss_rom_if.rom rom
);
	logic [31:0] entry_r;
	logic [31:0] entry_nxt;

	always_comb begin
		entry_nxt = CMD_TABLE[rom.idx];
	end

	always_ff @(posedge ref_clk_in) begin
		entry_r <= entry_nxt;
	end

	assign rom.entry = entry_r;
endmodule

/* rtl/gpss_pkg.sv */
// Package: constants and types shared by the status and service logic
package gpss_pkg;
	// Status byte field positions
	localparam int STAT_SELFTEST = 7;
	localparam int STAT_RQS = 6;
	localparam int STAT_ERR = 5;
	localparam int STAT_READY = 4;
	localparam int STAT_LINK = 3;
	localparam int STAT_PANEL = 2;
	localparam int STAT_LOCK = 1;
	localparam int STAT_BADCMD = 0;
	// Status reset value and the combined event patterns
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] PAT_FAIL = 8'he0;
	localparam logic [7:0] PAT_BADCMD = 8'h61;
	localparam logic [7:0] PAT_LOCK = 8'h62;
	localparam logic [7:0] PAT_PANEL = 8'h64;
	localparam logic [7:0] PAT_LINK = 8'h08;
	localparam logic [7:0] PAT_READY = 8'h10;
	localparam logic [7:0] PAT_READY_RQS = 8'h50;
	// Bits that survive a device clear
	localparam logic [7:0] DCL_KEEP = 8'h10;
	// Command framing characters
	localparam logic [7:0] CH_SEMI = 8'h3b;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam int CMD_LEN = 3;
	// Command table: three-character name and key code
	localparam int ROM_AW = 3;
	localparam int ROM_DEPTH = 8;
	localparam logic [31:0] CMD_TABLE [0:ROM_DEPTH-1] = '{
		32'h54_52_30_01, 32'h54_52_31_02, 32'h54_52_32_03, 32'h54_52_33_04,
		32'h4c_46_30_10, 32'h46_52_30_11, 32'h5a_4c_56_20, 32'h45_58_43_21};
	typedef enum logic [1:0] {CD_IDLE, CD_NAME, CD_LOOK, CD_DATA} gpss_cd_e;
endpackage

/* rtl/gpss_rom_if.sv */
// Interface: lookup path between command decoder and command table
`timescale 1ns/1ps
interface gpss_rom_if;
	logic [gpss_pkg::ROM_AW-1:0] idx;
	logic [31:0] entry;
	modport user (output idx, input entry);
	modport rom (input idx, output entry);
endinterface

/* rtl/gpss_status_top.sv */
// Serial poll status, service request and bus command intake
//
// Behaviour
// - Interface clear drops talker and listener addressing
// - Interface clear keeps queued data untouched
// - Interface clear abandons command decoding in progress
// - Interface clear leaves status and setup alone
// - Status byte fields at bits seven to zero
// - Bad command sets bit0, error, request
// - Lockout by other module sets bit1, error
// - Panel use in remote sets bit2, goes local
// - Status updates OR into existing byte
// - Link or slave mode sets bit three
// - Only device clear resets non-ready bits, except request on a full readout without error
// - Ready bit clears when all data read
// - Full readout without error releases request
// - Failure or bad command shows request message
// - Other requests leave display, may raise request
// - Ready, ready-with-request and failure byte patterns
// - Three-character commands become key sequences
// - Printed-output mode ignores all bus commands
// - Serial poll drives current status byte
// - Request line asserted while service needed
`timescale 1ns/1ps
module gpss_status_top import gpss_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic ifc_in,
	input wire logic talk_addr_in,
	input wire logic listen_addr_in,
	output logic talker_out,
	output logic listener_out,
	input wire logic dev_clear_in,
	input wire logic spoll_active_in,
	output logic [7:0] spoll_data_out,
	output logic spoll_oe_out,
	output logic srq_out,
	output logic srq_oe_out,
	input wire logic selftest_fail_in,
	input wire logic lockout_in,
	input wire logic remote_in,
	input wire logic panel_access_in,
	input wire logic link_busy_in,
	input wire logic data_avail_in,
	input wire logic all_read_in,
	input wire logic srq_on_data_in,
	output logic go_local_out,
	output logic srq_display_out,
	input wire logic printed_mode_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_char_in,
	output logic cmd_ready_out,
	output logic key_valid_out,
	output logic [7:0] key_code_out,
	output logic key_data_valid_out,
	output logic [7:0] key_data_out
);
	logic ifc_lvl;
	gpss_rom_if rom_bus ();

	gpss_sync3 u_ifc_sync (
		.ref_clk_in(ref_clk_in),
		.srst_in(srst_in),
		.pin_in(ifc_in),
		.level_out(ifc_lvl)
	);

	gpss_cmd_rom u_rom (
		.ref_clk_in(ref_clk_in),
		.rom(rom_bus)
	);

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);

	////////////////////////////////////////////////////////////////////////////////
	// Bus addressing

	logic talker_r, listener_r, talker_nxt, listener_nxt;

	always_comb begin
		talker_nxt = talker_r | talk_addr_in;
		listener_nxt = listener_r | listen_addr_in;
		if (ifc_lvl) begin
			talker_nxt = 1'b0;
			listener_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			talker_r <= 1'b0;
			listener_r <= 1'b0;
		end else begin
			talker_r <= talker_nxt;
			listener_r <= listener_nxt;
		end
	end

	assign talker_out = talker_r;
	assign listener_out = listener_r;

	a_ifc_unaddr: assert property (ifc_lvl |=> !talker_r && !listener_r)
		else $error("addressing kept across interface clear");

	////////////////////////////////////////////////////////////////////////////////
	// Command decoder

	gpss_cd_e cd_r, cd_nxt;
	logic [23:0] name_r, name_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic [ROM_AW-1:0] idx_r, idx_nxt, chk_r, chk_nxt;
	logic look_vld_r, look_vld_nxt;
	logic drop_r, drop_nxt;
	logic kv_r, kv_nxt, kdv_r, kdv_nxt;
	logic [7:0] kc_r, kc_nxt, kd_r, kd_nxt;
	logic bad_evt, take, term;

	// Lookup stalls intake so the table scan never loses a character
	assign cmd_ready_out = (cd_r != CD_LOOK);
	assign take = cmd_valid_in && cmd_ready_out;
	assign term = (cmd_char_in == CH_SEMI) || (cmd_char_in == CH_LF);
	assign rom_bus.idx = idx_r;

	always_comb begin
		cd_nxt = cd_r;
		name_nxt = name_r;
		cnt_nxt = cnt_r;
		idx_nxt = idx_r;
		chk_nxt = chk_r;
		look_vld_nxt = 1'b0;
		drop_nxt = drop_r;
		kv_nxt = 1'b0;
		kc_nxt = kc_r;
		kdv_nxt = 1'b0;
		kd_nxt = kd_r;
		bad_evt = 1'b0;
		case (cd_r)
			CD_IDLE, CD_NAME: begin
				if (take && term) begin
					// Name cut short by a terminator is a bad command
					bad_evt = (cd_r == CD_NAME);
					cd_nxt = CD_IDLE;
					cnt_nxt = 2'd0;
				end else if (take) begin
					name_nxt = {name_r[15:0], cmd_char_in};
					cnt_nxt = cnt_r + 2'd1;
					cd_nxt = CD_NAME;
					if (cnt_r == 2'(CMD_LEN - 1)) begin
						cd_nxt = CD_LOOK;
						cnt_nxt = 2'd0;
						idx_nxt = '0;
					end
				end
			end
			CD_LOOK: begin
				// Table data lags the index by one cycle
				look_vld_nxt = 1'b1;
				chk_nxt = idx_r;
				idx_nxt = idx_r + 1'b1;
				if (look_vld_r && rom_bus.entry[31:8] == name_r) begin
					kv_nxt = 1'b1;
					kc_nxt = rom_bus.entry[7:0];
					drop_nxt = 1'b0;
					cd_nxt = CD_DATA;
				end else if (look_vld_r && chk_r == ROM_AW'(ROM_DEPTH - 1)) begin
					bad_evt = 1'b1;
					drop_nxt = 1'b1;
					cd_nxt = CD_DATA;
				end
			end
			CD_DATA: begin
				if (take && term) begin
					cd_nxt = CD_IDLE;
				end else if (take && !drop_r) begin
					kdv_nxt = 1'b1;
					kd_nxt = cmd_char_in;
				end
			end
			default: begin
				cd_nxt = CD_IDLE;
			end
		endcase
		if (printed_mode_in) begin
			// Characters are still accepted so the bus never hangs
			cd_nxt = CD_IDLE;
			cnt_nxt = 2'd0;
			kv_nxt = 1'b0;
			kdv_nxt = 1'b0;
			bad_evt = 1'b0;
		end
		if (ifc_lvl) begin
			// Only the decoder is reset; data queues stay intact
			cd_nxt = CD_IDLE;
			cnt_nxt = 2'd0;
			kv_nxt = 1'b0;
			kdv_nxt = 1'b0;
			bad_evt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			cd_r <= CD_IDLE;
			name_r <= 24'h000000;
			cnt_r <= 2'd0;
			idx_r <= '0;
			chk_r <= '0;
			look_vld_r <= 1'b0;
			drop_r <= 1'b0;
			kv_r <= 1'b0;
			kc_r <= 8'h00;
			kdv_r <= 1'b0;
			kd_r <= 8'h00;
		end else begin
			cd_r <= cd_nxt;
			name_r <= name_nxt;
			cnt_r <= cnt_nxt;
			idx_r <= idx_nxt;
			chk_r <= chk_nxt;
			look_vld_r <= look_vld_nxt;
			drop_r <= drop_nxt;
			kv_r <= kv_nxt;
			kc_r <= kc_nxt;
			kdv_r <= kdv_nxt;
			kd_r <= kd_nxt;
		end
	end

	assign key_valid_out = kv_r;
	assign key_code_out = kc_r;
	assign key_data_valid_out = kdv_r;
	assign key_data_out = kd_r;

	sequence s_printed_hold;
		printed_mode_in [*2];
	endsequence

	a_ifc_abort: assert property (ifc_lvl |=> cd_r == CD_IDLE && !kv_r)
		else $error("decoding continued through interface clear");
	a_printed_ignore: assert property (s_printed_hold |=> !kv_r && !kdv_r)
		else $error("command acted on in printed-output mode");

	////////////////////////////////////////////////////////////////////////////////
	// Status byte and service request

	logic [7:0] stat_r, stat_nxt, set_v, clr_v;
	logic disp_r, disp_nxt, local_r, local_nxt, avail_d_r;
	logic [7:0] sp_r, sp_nxt;
	logic sp_oe_r, sp_oe_nxt;
	logic data_rise, panel_evt;

	assign data_rise = data_avail_in && !avail_d_r;
	assign panel_evt = panel_access_in && remote_in;

	always_comb begin
		set_v = 8'h00;
		clr_v = 8'h00;
		if (selftest_fail_in) set_v = set_v | PAT_FAIL;
		if (bad_evt) set_v = set_v | PAT_BADCMD;
		if (lockout_in) set_v = set_v | PAT_LOCK;
		if (panel_evt) set_v = set_v | PAT_PANEL;
		if (link_busy_in) set_v = set_v | PAT_LINK;
		if (data_rise) begin
			set_v = set_v | (srq_on_data_in ? PAT_READY_RQS : PAT_READY);
		end
		if (dev_clear_in) clr_v = ~DCL_KEEP;
		if (all_read_in) begin
			clr_v[STAT_READY] = 1'b1;
			if (!stat_r[STAT_ERR]) clr_v[STAT_RQS] = 1'b1;
		end
		// Sets win over clears and accumulate rather than overwrite
		stat_nxt = (stat_r & ~clr_v) | set_v;
		// Interface clear is deliberately absent here
		disp_nxt = (disp_r && !dev_clear_in) || selftest_fail_in || bad_evt;
		local_nxt = panel_evt;
		sp_nxt = stat_r;
		sp_oe_nxt = spoll_active_in;
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			stat_r <= STAT_RST;
			disp_r <= 1'b0;
			local_r <= 1'b0;
			avail_d_r <= 1'b0;
			sp_r <= 8'h00;
			sp_oe_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			disp_r <= disp_nxt;
			local_r <= local_nxt;
			avail_d_r <= data_avail_in;
			sp_r <= sp_nxt;
			sp_oe_r <= sp_oe_nxt;
		end
	end

	assign spoll_data_out = sp_r;
	assign spoll_oe_out = sp_oe_r;
	// Open-drain request line: pulled low while service is wanted
	assign srq_out = 1'b0;
	assign srq_oe_out = stat_r[STAT_RQS];
	assign go_local_out = local_r;
	assign srq_display_out = disp_r;

	sequence s_readout;
		all_read_in && !data_rise && !stat_r[STAT_ERR] && !bad_evt && !panel_evt
			&& !lockout_in && !selftest_fail_in;
	endsequence

	a_bad_bits: assert property (bad_evt |=> (stat_r & PAT_BADCMD) == PAT_BADCMD && disp_r)
		else $error("bad command not flagged");
	a_lock_bits: assert property (lockout_in |=> stat_r[STAT_LOCK] && stat_r[STAT_ERR])
		else $error("lockout not flagged");
	a_panel_local: assert property (panel_evt |=> go_local_out && stat_r[STAT_PANEL])
		else $error("panel access in remote not handled");
	a_or_keep: assert property (!dev_clear_in && !all_read_in
		|=> (stat_r & $past(stat_r)) == $past(stat_r))
		else $error("status bit lost without a clear");
	a_link_bit: assert property (link_busy_in |=> stat_r[STAT_LINK])
		else $error("link bit not set");
	// A full readout with no error may drop the request bit as well
	a_clear_only: assert property (!dev_clear_in && !(all_read_in && !stat_r[STAT_ERR])
		|=> ($past(stat_r) & ~DCL_KEEP & ~stat_r) == 8'h00)
		else $error("status bit cleared without device clear");
	a_ready_release: assert property (s_readout |=> !stat_r[STAT_READY]
		&& !stat_r[STAT_RQS] ##1 !srq_oe_out)
		else $error("readout did not release ready and request");
	a_spoll_drive: assert property (spoll_active_in |=> spoll_oe_out
		&& spoll_data_out == $past(stat_r))
		else $error("serial poll byte wrong");
	a_fail_byte: assert property (selftest_fail_in |=> stat_r[7:5] == 3'b111)
		else $error("failure byte wrong");
endmodule

/* rtl/gpss_sync3.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gpss_sync3 (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic pin_in,
	output logic level_out
);
	logic s1_r, s2_r, s3_r, lvl_r;
	logic lvl_nxt;

	always_comb begin
		// A change counts only once the last two stages agree
		lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			lvl_r <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign level_out = lvl_r;
endmodule

/* test/gpss_ctrl_model.sv */
// Bus controller model: command characters, serial poll, clear and readout
`timescale 1ns/1ps
module gpss_ctrl_model (
	input wire logic clk_in,
	input wire logic cmd_ready_in,
	input wire logic [7:0] spoll_data_in,
	input wire logic spoll_oe_in,
	output logic cmd_valid_out,
	output logic [7:0] cmd_char_out,
	output logic dev_clear_out,
	output logic spoll_active_out,
	output logic all_read_out
);
	logic hung = 1'b0;
	initial begin
		cmd_valid_out = 1'b0;
		cmd_char_out = 8'h00;
		dev_clear_out = 1'b0;
		spoll_active_out = 1'b0;
		all_read_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Characters go out most significant first, held until ready
	task automatic send(input logic [39:0] s, input int n);
		int k;
		@(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			#1 cmd_valid_out = 1'b1;
			cmd_char_out = s[39-8*i -: 8];
			for (k = 0; k < 20 && cmd_ready_in !== 1'b1; k++) begin
				@(posedge clk_in);
				#1;
			end
			if (k == 20) hung = 1'b1;
			@(posedge clk_in);
		end
		#1 cmd_valid_out = 1'b0;
		// Released data lines must not keep showing the last character
		cmd_char_out = ~cmd_char_out;
	endtask
	// One-cycle device clear (sel high) or all-data-read notice
	task automatic pulse(input logic sel);
		@(posedge clk_in);
		#1 dev_clear_out = sel;
		all_read_out = !sel;
		@(posedge clk_in);
		#1 dev_clear_out = 1'b0;
		all_read_out = 1'b0;
	endtask
	// Undriven data lines read as unknown so a missing enable cannot pass
	task automatic poll(output logic [7:0] b);
		@(posedge clk_in);
		#1 spoll_active_out = 1'b1;
		repeat (2) @(posedge clk_in);
		#1 b = spoll_oe_in ? spoll_data_in : 8'hxx;
		spoll_active_out = 1'b0;
	endtask
endmodule

/* test/tb_gpib_status_service_logic.sv */
// Testbench: status byte, service request, command intake, interface clear
`timescale 1ns/1ps
module tb_gpib_status_service_logic import gpss_pkg::*;;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ifc = 1'b0;
	logic remote = 1'b0;
	logic srq_mode = 1'b0;
	logic printed = 1'b0;
	logic [6:0] ev = 7'h00;
	logic cv, dcl, spa, ard, rdy, sp_oe, srq_oe, srq_v, tk, ls, gl, disp, kv, kdv;
	logic [7:0] cc, sp_d, kc, kd, key, kdat, b;
	int errors = 0;
	int checked = 0;
	int nkey = 0;
	int ngl = 0;
	logic [6:0] evm [6] = '{7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h01};
	logic [7:0] pat [6] = '{8'he0, 8'h62, 8'h64, 8'h08, 8'h10, 8'h50};
	always #20 clk = ~clk;
	gpss_status_top gpss_status_top_i (
		.ref_clk_in(clk), .srst_in(srst), .ifc_in(ifc), .talk_addr_in(ev[6]),
		.listen_addr_in(ev[5]), .talker_out(tk), .listener_out(ls),
		.dev_clear_in(dcl), .spoll_active_in(spa), .spoll_data_out(sp_d),
		.spoll_oe_out(sp_oe), .srq_out(srq_v), .srq_oe_out(srq_oe),
		.selftest_fail_in(ev[4]), .lockout_in(ev[3]), .remote_in(remote),
		.panel_access_in(ev[2]), .link_busy_in(ev[1]), .data_avail_in(ev[0]),
		.all_read_in(ard), .srq_on_data_in(srq_mode), .go_local_out(gl),
		.srq_display_out(disp), .printed_mode_in(printed), .cmd_valid_in(cv),
		.cmd_char_in(cc), .cmd_ready_out(rdy), .key_valid_out(kv), .key_code_out(kc),
		.key_data_valid_out(kdv), .key_data_out(kd));
	gpss_ctrl_model gpss_ctrl_model_i (
		.clk_in(clk), .cmd_ready_in(rdy), .spoll_data_in(sp_d), .spoll_oe_in(sp_oe),
		.cmd_valid_out(cv), .cmd_char_out(cc), .dev_clear_out(dcl),
		.spoll_active_out(spa), .all_read_out(ard));
	// One-cycle pulses are caught mid-cycle, clear of edge races
	always @(negedge clk) begin
		if (kv === 1'b1) begin
			nkey++;
			key = kc;
		end
		if (kdv === 1'b1) kdat = kd;
		if (gl === 1'b1) ngl++;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] z(input logic v);
		return {7'h00, v};
	endfunction
	function automatic logic [7:0] code_of(input logic [23:0] nm);
		code_of = 8'hff;
		for (int i = 0; i < ROM_DEPTH; i++)
			if (CMD_TABLE[i][31:8] == nm) code_of = CMD_TABLE[i][7:0];
	endfunction
	task automatic finish_test;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: exp %h got %h", $time, e, g);
		end
	endtask
	task automatic pulse(input logic [6:0] m);
		@(posedge clk);
		#1 ev = m;
		@(posedge clk);
		#1 ev = 7'h00;
	endtask
	task automatic st(input logic [7:0] e);
		gpss_ctrl_model_i.poll(b);
		chk(e, b);
		// Request line must pull low while enabled
		chk(z(e[6]), z(srq_oe && srq_v === 1'b0));
	endtask
	// Expected code 8'hff means no key may come out
	task automatic cmd(input logic [39:0] s, input int n, input logic [7:0] e);
		int n0;
		n0 = nkey;
		gpss_ctrl_model_i.send(s, n);
		repeat (4) @(posedge clk);
		if (gpss_ctrl_model_i.hung) begin
			errors++;
			finish_test();
		end
		chk(z(e != 8'hff), z(nkey == n0 + 1));
		if (e != 8'hff) chk(e, key);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [23:0] nm;
		logic [7:0] d;
		int n;
		void'($urandom(32'ha3b8));
		repeat (16) @(posedge clk);
		#1 srst = 1'b0;
		st(8'h00);
		chk(8'h01, z(rdy));
		for (int i = 0; i < 6; i++) begin
			gpss_ctrl_model_i.pulse(1'b1);
			srq_mode = (i == 5);
			// Remote and printed mode are don't-cares here unless the panel is used
			remote = (i == 2) || 1'($urandom % 2);
			printed = 1'($urandom % 2);
			n = ngl;
			pulse(evm[i]);
			st(pat[i]);
			chk(z(i == 0), z(disp));
			chk(z(i == 2), z(ngl == n + 1));
		end
		gpss_ctrl_model_i.pulse(1'b0);
		st(8'h00);
		pulse(7'h09);
		st(8'h72);
		gpss_ctrl_model_i.pulse(1'b1);
		st(8'h10);
		pulse(7'h08);
		gpss_ctrl_model_i.pulse(1'b0);
		st(8'h62);
		pulse(7'h02);
		st(8'h6a);
		gpss_ctrl_model_i.pulse(1'b1);
		st(8'h00);
		printed = 1'b0;
		for (int i = 0; i < 6; i++) begin
			nm = CMD_TABLE[$urandom % ROM_DEPTH][31:8];
			d = 8'(8'h30 + $urandom % 10);
			cmd({nm, d, ($urandom % 2) ? CH_SEMI : CH_LF}, 5, code_of(nm));
			chk(d, kdat);
		end
		cmd({"QQQ", 8'h31, CH_SEMI}, 5, 8'hff);
		st(8'h61);
		chk(8'h01, z(disp));
		gpss_ctrl_model_i.pulse(1'b1);
		printed = 1'b1;
		cmd({"QQQ", 8'h32, CH_LF}, 5, 8'hff);
		cmd({"TR0", 8'h33, CH_SEMI}, 5, 8'hff);
		st(8'h00);
		printed = 1'b0;
		pulse(7'h62);
		chk(8'h03, {6'h00, tk, ls});
		// Half a name, then clear: a surviving prefix would spoil the next name
		gpss_ctrl_model_i.send({"TR", 24'h000000}, 2);
		ifc = 1'b1;
		repeat (6) @(posedge clk);
		#1 chk(8'h00, {6'h00, tk, ls});
		ifc = 1'b0;
		repeat (6) @(posedge clk);
		cmd({"TR1", 8'h37, CH_LF}, 5, 8'h02);
		st(8'h08);
		finish_test();
	end
endmodule
